// ===== src/usbir_baud.sv
// Baud generator giving one pulse per 16x sample slot.
`timescale 1ns/10ps
module usbir_baud
  import usbir_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Divisor, bus clocks per slot minus one
  input  wire logic [7:0] divisor,
  // Slot pulse
  output logic            tick
);
  logic [7:0] cnt_q;
  wire        wrap = (cnt_q >= divisor);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      tick  <= 1'b0;
    end else begin
      cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
      tick  <= wrap;
    end
  end
endmodule : usbir_baud

// ===== src/usbir_dev.sv
// Serial port end: status flags, break and idle queueing, 16x receiver.
`timescale 1ns/10ps
module usbir_dev
  import usbir_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // Serial link
  usbir_if.dev            link
);
  typedef enum logic [1:0] {RX_HUNT, RX_START, RX_DATA, RX_STOP}
    usbir_rx_e;

  logic [7:0]  ctrl_q, baud_q, arm_q, rdata_q;
  logic        tx_buffer_empty_flag_q, tc_q, rx_buffer_full_flag_q, idle_q, or_q, nf_q, fe_q;
  logic        tick16;
  logic [3:0]  tx_sub_q, tx_left_q;
  logic [13:0] tx_sh_q;
  logic [7:0]  buf_q;
  logic        buf_full_q, brk_pend_q, idle_pend_q, txd_q, txd_oe_q;
  usbir_rx_e   rx_st_q;
  logic [2:0]  hist_q, ver_q;
  logic [1:0]  vote_q;
  logic [4:0]  rt_q;
  logic [3:0]  rbits_q;
  logic [8:0]  rsh_q;
  logic [7:0]  rdat_q, idle_cnt_q;
  logic        noise_q, idle_allow_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.
  wire       te      = ctrl_q[CT_TE];
  wire       re      = ctrl_q[CT_RE];
  wire       nine    = ctrl_q[CT_M];
  wire       wr_data = reg_wr && (reg_addr == ADDR_DATA);
  wire       wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
  wire       wr_baud = reg_wr && (reg_addr == ADDR_BAUD);
  wire       rd_stat = reg_rd && (reg_addr == ADDR_STATUS);
  wire       rd_data = reg_rd && (reg_addr == ADDR_DATA);
  wire       te_rise = wr_ctrl && reg_wdata[CT_TE] && !te;
  wire       sbk_set = wr_ctrl && reg_wdata[CT_SBK];
  wire [7:0] stat    = {tx_buffer_empty_flag_q, tc_q, rx_buffer_full_flag_q, idle_q, or_q, nf_q, fe_q,
                        1'b0};
  wire [7:0] rd_mux  = (reg_addr == ADDR_STATUS) ? stat   :
                       (reg_addr == ADDR_DATA)   ? rdat_q :
                       (reg_addr == ADDR_CTRL)   ? ctrl_q :
                       (reg_addr == ADDR_BAUD)   ? baud_q : 8'h00;
  // A flag other than TC clears only when the preceding status read saw it set.
  wire       clr_rx  = rd_data;
  wire       clr_tx  = wr_data;

  assign reg_rdata   = rdata_q;
  assign link.dev_tx    = txd_q;
  assign link.dev_tx_oe = txd_oe_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q  <= CTRL_RESET;
      baud_q  <= BAUD_RESET;
      rdata_q <= 8'h00;
      arm_q   <= 8'h00;
    end else begin
      if (wr_ctrl) ctrl_q <= reg_wdata;
      if (wr_baud) baud_q <= reg_wdata;
      rdata_q <= reg_rd ? rd_mux : 8'h00;
      if (rd_stat) arm_q <= stat;
      else if (rd_data || wr_data) arm_q <= 8'h00;
    end
  end

  usbir_baud u_baud (
    .ref_clk (ref_clk),
    .rst     (rst),
    .divisor (baud_q),
    .tick    (tick16)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter.
  wire        bit_tick = tick16 && (tx_sub_q == SUB_LAST);
  wire        tx_more  = (tx_left_q > 4'h1);
  wire        tx_free  = bit_tick && !tx_more;
  wire        busy     = (tx_left_q != 4'h0);
  wire        ld_data  = tx_free && buf_full_q && te;
  wire        ld_brk   = tx_free && !ld_data && brk_pend_q;
  wire        ld_idle  = tx_free && !ld_data && !brk_pend_q && idle_pend_q;
  wire        ld_any   = ld_data || ld_brk || ld_idle;
  wire [13:0] d_frame  = nine ? {4'hf, ctrl_q[CT_T8], buf_q, 1'b0}
                              : {5'h1f, buf_q, 1'b0};
  wire [13:0] ld_frame = ld_data ? d_frame :
                         (ld_brk ? FRAME_BREAK : FRAME_MARK);
  wire [3:0]  ld_len   = ld_brk ? break_bits(ctrl_q[CT_LONG_BREAK_SELECT], nine)
                                : char_bits(nine);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_sub_q  <= 4'h0;
      tx_left_q <= 4'h0;
      tx_sh_q   <= FRAME_MARK;
      txd_q     <= 1'b1;
    end else begin
      if (tick16) tx_sub_q <= tx_sub_q + 4'h1;
      if (bit_tick) begin
        if (tx_more) begin
          txd_q     <= tx_sh_q[0];
          tx_sh_q   <= {1'b1, tx_sh_q[13:1]};
          tx_left_q <= tx_left_q - 4'h1;
        end else if (ld_any) begin
          txd_q     <= ld_frame[0];
          tx_sh_q   <= {1'b1, ld_frame[13:1]};
          tx_left_q <= ld_len;
        end else begin
          txd_q     <= 1'b1;
          tx_left_q <= 4'h0;
        end
      end
    end
  end

  // Queue bookkeeping; a new request in the load cycle wins over the load.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      buf_q       <= 8'h00;
      buf_full_q  <= 1'b0;
      brk_pend_q  <= 1'b0;
      idle_pend_q <= 1'b0;
      tx_buffer_empty_flag_q      <= 1'b1;
      tc_q        <= 1'b1;
      txd_oe_q    <= 1'b0;
    end else begin
      if (wr_data) buf_q <= reg_wdata;
      buf_full_q <= wr_data || (buf_full_q && !ld_data);
      if (sbk_set) brk_pend_q <= 1'b1;
      else if (ld_brk) brk_pend_q <= ctrl_q[CT_SBK];
      if (te_rise) idle_pend_q <= 1'b1;
      else if (ld_idle) idle_pend_q <= 1'b0;
      tx_buffer_empty_flag_q <= ld_data || (tx_buffer_empty_flag_q && !(clr_tx && arm_q[ST_TX_BUFFER_EMPTY_FLAG]));
      // Any queued work shows as activity, so the request itself ends the flag without a status read.
      tc_q <= !buf_full_q && !busy && !brk_pend_q && !idle_pend_q
              && !wr_data && !te_rise && !sbk_set;
      // Pin stays ours while enabled and until the shifter, queued break and idle are done; a buffered character does not hold it.
      txd_oe_q <= te || busy || brk_pend_q || idle_pend_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver.
  wire       rx_s    = link.rem_tx ^ ctrl_q[CT_RX_POLARITY_INVERT];
  wire       smp     = tick16 && re;
  wire       vote    = maj3(vote_q[1], vote_q[0], rx_s);
  wire       disagree = !((vote_q[1] == vote_q[0]) && (vote_q[0] == rx_s));
  wire       at_vote = (rt_q == RT_VOTE_C);
  wire       fr_done = smp && (rx_st_q == RX_STOP) && at_vote;
  wire [7:0] fr_data = nine ? rsh_q[7:0] : rsh_q[8:1];
  wire       fr_nz   = noise_q || disagree;
  // Frames are dropped while a framing error waits to be cleared.
  wire       xfer    = fr_done && !fe_q && !rx_buffer_full_flag_q;
  wire       ovr     = fr_done && !fe_q && rx_buffer_full_flag_q;
  wire [3:0] dbits   = nine ? DATA_BITS_NINE : DATA_BITS_EIGHT;
  wire       ver_bad = maj3(ver_q[1], ver_q[0], rx_s);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_st_q <= RX_HUNT;
      hist_q  <= HIST_SPACE;
      ver_q   <= 3'h0;
      vote_q  <= 2'h0;
      rt_q    <= RT_FIRST;
      rbits_q <= 4'h0;
      rsh_q   <= 9'h000;
      noise_q <= 1'b0;
    end else if (!re) begin
      rx_st_q <= RX_HUNT;
      hist_q  <= HIST_SPACE;
    end else if (smp) begin
      rt_q <= (rt_q == RT_LAST) ? RT_FIRST : rt_q + 5'h01;
      if ((rt_q == RT_VOTE_A) || (rt_q == RT_VOTE_B))
        vote_q <= {vote_q[0], rx_s};
      case (rx_st_q)
        RX_HUNT: begin
          hist_q <= {hist_q[1:0], rx_s};
          if (!rx_s && (hist_q == HIST_MARK)) begin
            rx_st_q <= RX_START;
            rt_q    <= RT_FIRST + 5'h01;
            noise_q <= 1'b0;
          end
        end
        RX_START: begin
          if ((rt_q == RT_VERIFY_A) || (rt_q == RT_VERIFY_B))
            ver_q <= {ver_q[1:0], rx_s};
          if (rt_q == RT_VERIFY_C) begin
            noise_q <= ver_q[1] || ver_q[0] || rx_s;
            if (ver_bad) begin
              rx_st_q <= RX_HUNT;
              hist_q  <= HIST_SPACE;
            end
          end
          // The start bit counts as 0 even if the late samples disagree.
          if (at_vote) noise_q <= noise_q || vote_q[1] || vote_q[0] || rx_s;
          if (rt_q == RT_LAST) begin
            rx_st_q <= RX_DATA;
            rbits_q <= 4'h0;
          end
        end
        RX_DATA: begin
          if (at_vote) begin
            rsh_q   <= {vote, rsh_q[8:1]};
            noise_q <= fr_nz;
          end
          if (rt_q == RT_LAST) begin
            if (rbits_q == dbits - 4'h1) rx_st_q <= RX_STOP;
            else rbits_q <= rbits_q + 4'h1;
          end
        end
        RX_STOP: begin
          if (at_vote) begin
            rx_st_q <= RX_HUNT;
            // Only a real break keeps the edge search waiting for a mark.
            hist_q <= (vote || (fr_data != 8'h00)) ? HIST_MARK : HIST_SPACE;
          end
        end
        default: rx_st_q <= RX_HUNT;
      endcase
    end
  end

  // Idle line detection counts high slots since the last low sample; with CT_ILT set, only those while hunting.
  wire       idle_cnt_en = ctrl_q[CT_ILT] ? (rx_st_q == RX_HUNT) : 1'b1;
  wire [7:0] idle_lim    = idle_limit(nine);
  wire       idle_hit    = smp && rx_s && idle_cnt_en
                           && (idle_cnt_q == idle_lim - 8'h01);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idle_cnt_q   <= 8'h00;
      idle_allow_q <= 1'b0;
      rdat_q       <= 8'h00;
      rx_buffer_full_flag_q       <= 1'b0;
      idle_q       <= 1'b0;
      or_q         <= 1'b0;
      nf_q         <= 1'b0;
      fe_q         <= 1'b0;
    end else begin
      if (smp) begin
        if (!rx_s) idle_cnt_q <= 8'h00;
        else if (idle_cnt_en && (idle_cnt_q != idle_lim))
          idle_cnt_q <= idle_cnt_q + 8'h01;
      end
      if (xfer) idle_allow_q <= 1'b1;
      else if (idle_hit) idle_allow_q <= 1'b0;
      if (xfer) rdat_q <= fr_data;
      rx_buffer_full_flag_q <= xfer || (rx_buffer_full_flag_q && !(clr_rx && arm_q[ST_RX_BUFFER_FULL_FLAG]));
      idle_q <= (idle_hit && idle_allow_q)
                || (idle_q && !(clr_rx && arm_q[ST_IDLE]));
      or_q   <= ovr || (or_q && !(clr_rx && arm_q[ST_OR]));
      nf_q   <= (xfer && fr_nz) || (nf_q && !(clr_rx && arm_q[ST_NF]));
      fe_q   <= (xfer && !vote)
                || (fe_q && !(clr_rx && arm_q[ST_FE]));
    end
  end
endmodule : usbir_dev

// ===== src/usbir_if.sv
// Serial link between the port and the remote serial party.
`timescale 1ns/10ps
interface usbir_if;
  logic dev_tx;
  logic dev_tx_oe;
  logic rem_tx;
  logic line_to_rem;

  // A released transmit pin is held high from outside the port.
  assign line_to_rem = dev_tx_oe ? dev_tx : 1'b1;

  modport dev (output dev_tx, output dev_tx_oe, input rem_tx);
  modport rem (input line_to_rem, output rem_tx);
endinterface : usbir_if

// ===== src/usbir_pkg.sv
// Constants, register map and helper functions shared by both serial ends.
// Overview of operation
// - Transmit complete set when transmitter fully idle.
// - Transmit complete clears on any queued action, no status read needed.
// - Receive full sets on transfer, clears read-then-read.
// - Idle flag after full high character time.
// - Overrun on unread data; new character discarded.
// - Seven start samples, three per bit, noise.
// - Pin held until shifter, queued break and idle finish.
// - Break bit queues breaks, repeats while held.
// - Break length 10, 11, 13 or 14 bits.
// - Received break gives zero data, framing error.
// - Enable toggle queues one idle character.
// - Released pin is held high externally.
// - Receive input inversion and receiver enable.
// - Frame: start 0, data LSB first, stop 1.
// - Completed character moves to empty data register.
// - Buffer empty sets on load, clears read-then-write.
// - Framing error blocks transfers until cleared.
// - Receiver samples at sixteen slots per bit.
package usbir_pkg;

  // Register addresses.
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_DATA   = 3'h1;
  localparam logic [2:0] ADDR_CTRL   = 3'h2;
  localparam logic [2:0] ADDR_BAUD   = 3'h3;

  // Status bit positions.
  localparam int unsigned ST_TX_BUFFER_EMPTY_FLAG = 7;
  localparam int unsigned ST_TC   = 6;
  localparam int unsigned ST_RX_BUFFER_FULL_FLAG = 5;
  localparam int unsigned ST_IDLE = 4;
  localparam int unsigned ST_OR   = 3;
  localparam int unsigned ST_NF   = 2;
  localparam int unsigned ST_FE   = 1;

  // Control bit positions.
  localparam int unsigned CT_TE    = 0;
  localparam int unsigned CT_RE    = 1;
  localparam int unsigned CT_SBK   = 2;
  localparam int unsigned CT_LONG_BREAK_SELECT = 3;
  localparam int unsigned CT_M     = 4;
  localparam int unsigned CT_ILT   = 5;
  localparam int unsigned CT_RX_POLARITY_INVERT = 6;
  localparam int unsigned CT_T8    = 7;

  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h0f;

  // Timing in 16x sample slots and bit times.
  localparam logic [3:0] SUB_LAST        = 4'hf;
  localparam logic [4:0] RT_FIRST        = 5'h01;
  localparam logic [4:0] RT_VERIFY_A     = 5'h03;
  localparam logic [4:0] RT_VERIFY_B     = 5'h05;
  localparam logic [4:0] RT_VERIFY_C     = 5'h07;
  localparam logic [4:0] RT_VOTE_A       = 5'h08;
  localparam logic [4:0] RT_VOTE_B       = 5'h09;
  localparam logic [4:0] RT_VOTE_C       = 5'h0a;
  localparam logic [4:0] RT_LAST         = 5'h10;
  localparam logic [3:0] CHAR_BITS_EIGHT = 4'ha;
  localparam logic [3:0] CHAR_BITS_NINE  = 4'hb;
  localparam logic [3:0] BREAK_EXTRA     = 4'h3;
  localparam logic [3:0] DATA_BITS_EIGHT = 4'h8;
  localparam logic [3:0] DATA_BITS_NINE  = 4'h9;
  localparam logic [2:0] HIST_MARK       = 3'h7;
  localparam logic [2:0] HIST_SPACE      = 3'h0;
  localparam logic [13:0] FRAME_BREAK    = 14'h0000;
  localparam logic [13:0] FRAME_MARK     = 14'h3fff;

  function automatic logic [3:0] char_bits(input logic nine);
    return nine ? CHAR_BITS_NINE : CHAR_BITS_EIGHT;
  endfunction : char_bits

  function automatic logic [3:0] break_bits(input logic lng,
                                            input logic nine);
    return char_bits(nine) + (lng ? BREAK_EXTRA : 4'h0);
  endfunction : break_bits

  function automatic logic [7:0] idle_limit(input logic nine);
    return {char_bits(nine), 4'h0};
  endfunction : idle_limit

  function automatic logic maj3(input logic a, input logic b,
                                input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction : maj3

endpackage : usbir_pkg

// ===== src/usbir_rem.sv
// Remote serial party: plain 8-bit transmitter and receiver on the link.
`timescale 1ns/10ps
module usbir_rem
  import usbir_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Baud setting
  input  wire logic [7:0] divisor,
  // Send side
  input  wire logic       send_valid,
  input  wire logic [7:0] send_data,
  output logic            send_ready,
  // Receive side
  output logic            recv_valid,
  output logic [7:0]      recv_data,
  output logic            recv_ferr,
  // Serial link
  usbir_if.rem            link
);
  logic       tick16, tx_q, rx_busy_q;
  logic [3:0] tx_sub_q, tx_left_q, rx_bits_q;
  logic [9:0] tx_sh_q;
  logic [4:0] rx_rt_q;
  logic [8:0] rx_sh_q;

  assign link.rem_tx = tx_q;

  usbir_baud u_baud (
    .ref_clk (ref_clk),
    .rst     (rst),
    .divisor (divisor),
    .tick    (tick16)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter; a character is accepted only while idle.
  wire bit_tick = tick16 && (tx_sub_q == SUB_LAST);
  wire take     = send_valid && send_ready;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_sub_q   <= 4'h0;
      tx_left_q  <= 4'h0;
      tx_sh_q    <= 10'h3ff;
      tx_q       <= 1'b1;
      send_ready <= 1'b1;
    end else begin
      if (tick16) tx_sub_q <= tx_sub_q + 4'h1;
      if (take) begin
        tx_sh_q    <= {1'b1, send_data, 1'b0};
        tx_left_q  <= CHAR_BITS_EIGHT;
        send_ready <= 1'b0;
      end else if (bit_tick && (tx_left_q != 4'h0)) begin
        tx_q      <= tx_sh_q[0];
        tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
        tx_left_q <= tx_left_q - 4'h1;
      end else if (bit_tick) begin
        tx_q       <= 1'b1;
        send_ready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver samples each bit once, mid-bit.
  wire rx_s = link.line_to_rem;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_busy_q  <= 1'b0;
      rx_rt_q    <= RT_FIRST;
      rx_bits_q  <= 4'h0;
      rx_sh_q    <= 9'h000;
      recv_valid <= 1'b0;
      recv_data  <= 8'h00;
      recv_ferr  <= 1'b0;
    end else begin
      recv_valid <= 1'b0;
      if (tick16) begin
        if (!rx_busy_q) begin
          if (!rx_s) begin
            rx_busy_q <= 1'b1;
            rx_rt_q   <= RT_FIRST + 5'h01;
            rx_bits_q <= 4'h0;
          end
        end else begin
          rx_rt_q <= (rx_rt_q == RT_LAST) ? RT_FIRST : rx_rt_q + 5'h01;
          if (rx_rt_q == RT_VOTE_B) begin
            rx_sh_q   <= {rx_s, rx_sh_q[8:1]};
            rx_bits_q <= rx_bits_q + 4'h1;
            if (rx_bits_q == DATA_BITS_NINE) begin
              rx_busy_q  <= 1'b0;
              recv_valid <= 1'b1;
              recv_data  <= rx_sh_q[8:1];
              recv_ferr  <= !rx_s;
            end
          end
        end
      end
    end
  end
endmodule : usbir_rem

// ===== test/tb_top.sv
// Bench driving the serial port registers against the remote end.
`timescale 1ns/10ps
module tb_top
  import usbir_pkg::*;
;
  localparam logic [7:0] M_TX_BUFFER_EMPTY_FLAG = 8'h01 << ST_TX_BUFFER_EMPTY_FLAG;
  localparam logic [7:0] M_TC   = 8'h01 << ST_TC;
  localparam logic [7:0] M_RX_BUFFER_FULL_FLAG = 8'h01 << ST_RX_BUFFER_FULL_FLAG;
  localparam logic [7:0] M_IDLE = 8'h01 << ST_IDLE;
  localparam logic [7:0] M_OR   = 8'h01 << ST_OR;
  localparam logic [7:0] C_TE   = 8'h01 << CT_TE;
  localparam logic [7:0] C_RE   = 8'h01 << CT_RE;

  logic       ref_clk    = 1'b0;
  logic       rst        = 1'b1;
  logic [2:0] reg_addr   = 3'h0;
  logic [7:0] reg_wdata  = 8'h00;
  logic       reg_wr     = 1'b0;
  logic       reg_rd     = 1'b0;
  logic [7:0] reg_rdata;
  logic       send_valid = 1'b0;
  logic [7:0] send_data  = 8'h00;
  logic       send_ready;
  logic       recv_valid;
  logic [7:0] recv_data;
  logic       recv_ferr;
  int         bad_count  = 0;
  int         checked    = 0;
  int         run_len    = 0;
  int         last_run   = 0;

  always #2 ref_clk = ~ref_clk;

  usbir_if lnk ();
  usbir_dev u_usbir_dev (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(lnk));
  usbir_rem u_usbir_rem (.ref_clk(ref_clk), .rst(rst), .divisor(8'h00),
    .send_valid(send_valid), .send_data(send_data),
    .send_ready(send_ready), .recv_valid(recv_valid),
    .recv_data(recv_data), .recv_ferr(recv_ferr), .link(lnk));
  usbir_link_sva u_usbir_link_sva (.ref_clk(ref_clk), .rst(rst),
    .dev_tx(lnk.dev_tx), .dev_tx_oe(lnk.dev_tx_oe),
    .rem_tx(lnk.rem_tx), .line_to_rem(lnk.line_to_rem));

  // Length of the last low stretch seen on the resolved pin.
  always @(posedge ref_clk) begin
    if (!lnk.line_to_rem) run_len <= run_len + 1;
    else begin
      if (run_len != 0) last_run <= run_len;
      run_len <= 0;
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk_n(input int got, input int exp);
    checked++;
    if (got != exp) begin
      bad_count++;
      $display("Error at %0t: length %0d expected %0d", $time, got, exp);
    end
  endtask : chk_n

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic chk_reg(input logic [2:0] a, input logic [7:0] m,
                         input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk8(v & m, e);
  endtask : chk_reg

  // Polling arms the flags, so a data access after it clears them.
  task automatic wait_st(input logic [7:0] m);
    logic [7:0] s = 8'h00;
    for (int i = 0; i < 400 && (s & m) != m; i++) rd(ADDR_STATUS, s);
    chk8(s & m, m);
  endtask : wait_st

  task automatic send(input logic [7:0] d);
    @(posedge ref_clk);
    send_valid <= 1'b1;
    send_data <= d;
    #1;
    for (int i = 0; i < 2000 && send_ready !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    send_valid <= 1'b0;
  endtask : send

  task automatic wait_recv(input logic [7:0] d, input logic fe);
    @(posedge ref_clk);
    #1;
    for (int i = 0; i < 2000 && recv_valid !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk8(recv_data, d);
    chk8({7'h00, recv_ferr}, {7'h00, fe});
  endtask : wait_recv

  ////////////////////////////////////////////////////////////
  task automatic test_reset();
    chk_reg(ADDR_STATUS, 8'hff, M_TX_BUFFER_EMPTY_FLAG | M_TC);
    chk_reg(ADDR_CTRL, 8'hff, CTRL_RESET);
    chk_reg(ADDR_BAUD, 8'hff, BAUD_RESET);
    chk_reg(3'h5, 8'hff, 8'h00);
    wr(ADDR_STATUS, 8'h3f);
    chk_reg(ADDR_STATUS, 8'hff, M_TX_BUFFER_EMPTY_FLAG | M_TC);
    wr(ADDR_BAUD, 8'h00);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_tx();
    wr(ADDR_CTRL, C_TE);
    chk_reg(ADDR_STATUS, M_TC, 8'h00);
    wait_st(M_TC);
    wr(ADDR_DATA, 8'ha5);
    repeat (20) @(posedge ref_clk);
    chk_reg(ADDR_STATUS, M_TX_BUFFER_EMPTY_FLAG | M_TC, M_TX_BUFFER_EMPTY_FLAG);
    wr(ADDR_DATA, 8'h5a);
    chk_reg(ADDR_STATUS, M_TX_BUFFER_EMPTY_FLAG, 8'h00);
    wait_recv(8'ha5, 1'b0);
    wait_recv(8'h5a, 1'b0);
    wait_st(M_TC | M_TX_BUFFER_EMPTY_FLAG);
    $display("test_tx done");
  endtask : test_tx

  task automatic test_release();
    wr(ADDR_DATA, 8'h81);
    repeat (20) @(posedge ref_clk);
    wr(ADDR_CTRL, 8'h00);
    chk_reg(ADDR_STATUS, M_TC, 8'h00);
    chk8({7'h00, lnk.dev_tx_oe}, 8'h01);
    wait_recv(8'h81, 1'b0);
    wait_st(M_TC);
    chk8({7'h00, lnk.dev_tx_oe}, 8'h00);
    wr(ADDR_CTRL, C_TE);
    chk_reg(ADDR_STATUS, M_TC, 8'h00);
    chk8({7'h00, lnk.dev_tx_oe}, 8'h01);
    wait_st(M_TC);
    $display("test_release done");
  endtask : test_release

  task automatic test_rx();
    logic [7:0] v;
    send(8'h3c);
    repeat (200) @(posedge ref_clk);
    chk_reg(ADDR_STATUS, M_RX_BUFFER_FULL_FLAG, 8'h00);
    wr(ADDR_CTRL, C_TE | C_RE);
    send(8'h3c);
    wait_st(M_RX_BUFFER_FULL_FLAG);
    chk_reg(ADDR_DATA, 8'hff, 8'h3c);
    chk_reg(ADDR_STATUS, M_RX_BUFFER_FULL_FLAG, 8'h00);
    wait_st(M_IDLE);
    rd(ADDR_DATA, v);
    repeat (400) @(posedge ref_clk);
    chk_reg(ADDR_STATUS, M_IDLE, 8'h00);
    $display("test_rx done");
  endtask : test_rx

  task automatic test_overrun();
    send(8'h11);
    send(8'h22);
    wait_st(M_OR | M_RX_BUFFER_FULL_FLAG);
    chk_reg(ADDR_DATA, 8'hff, 8'h11);
    chk_reg(ADDR_STATUS, M_OR | M_RX_BUFFER_FULL_FLAG, 8'h00);
    $display("test_overrun done");
  endtask : test_overrun

  // The break bit is held until the first break starts, so exactly one
  // more break must follow it back to back.
  task automatic test_break();
    logic [7:0] cfg;
    for (int k = 0; k < 4; k++) begin
      cfg = C_TE | (k[0] << CT_M) | (k[1] << CT_LONG_BREAK_SELECT);
      wr(ADDR_CTRL, cfg | (8'h01 << CT_SBK));
      chk_reg(ADDR_STATUS, M_TC, 8'h00);
      for (int i = 0; i < 100 && lnk.line_to_rem !== 1'b0; i++)
        @(posedge ref_clk);
      wr(ADDR_CTRL, cfg);
      wait_recv(8'h00, 1'b1);
      wait_st(M_TC);
      chk_n(last_run, 2 * 16 * (10 + k[0] + 3 * k[1]));
      // The remote end restarts on the held low line, so a stray frame
      // may still be in flight; let it finish before the next break.
      repeat (200) @(posedge ref_clk);
    end
    $display("test_break done");
  endtask : test_break

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    test_reset();
    test_tx();
    test_release();
    test_rx();
    test_overrun();
    test_break();
    test_done();
  end

  // The whole run needs well under a fifth of this span.
  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    test_done();
  end
endmodule : tb_top

// ===== test/usbir_link_sva.sv
// Assertions on the serial link between the port and the remote end.
`timescale 1ns/10ps
module usbir_link_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Link signals
  input wire logic dev_tx,
  input wire logic dev_tx_oe,
  input wire logic rem_tx,
  input wire logic line_to_rem
);
  // The bench runs both ends with divisor 0, so one bit is 16 clocks.
  localparam int BIT_CLKS    = 16;
  localparam int REM_MAX_LOW = 144;

  logic [11:0] dev_lo_q;
  logic [11:0] rem_lo_q;
  logic [11:0] dev_hi_q;

  // Run lengths; the high run saturates since idle may last forever.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dev_lo_q <= 12'h000;
      rem_lo_q <= 12'h000;
      dev_hi_q <= 12'h000;
    end else begin
      dev_lo_q <= dev_tx ? 12'h000 : dev_lo_q + 12'h001;
      rem_lo_q <= rem_tx ? 12'h000 : rem_lo_q + 12'h001;
      dev_hi_q <= !dev_tx ? 12'h000 :
                  (&dev_hi_q ? dev_hi_q : dev_hi_q + 12'h001);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////
  property p_idle_high; !dev_tx_oe |-> dev_tx; endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("device line low while released");
  property p_release_high; !dev_tx_oe |-> line_to_rem; endproperty
  a_release_high: assert property (p_release_high)
    else $error("released pin not high");
  property p_drive_pass; dev_tx_oe |-> line_to_rem == dev_tx; endproperty
  a_drive_pass: assert property (p_drive_pass)
    else $error("driven pin does not follow device output");
  property p_dev_start;
    $fell(dev_tx) |-> !dev_tx [*8] ##1 !dev_tx [*8];
  endproperty
  a_dev_start: assert property (p_dev_start)
    else $error("device low run shorter than one bit");
  property p_rem_start;
    $fell(rem_tx) |-> !rem_tx [*8] ##1 !rem_tx [*8];
  endproperty
  a_rem_start: assert property (p_rem_start)
    else $error("remote low run shorter than one bit");
  property p_dev_bits; $rose(dev_tx) |-> dev_lo_q % BIT_CLKS == 0; endproperty
  a_dev_bits: assert property (p_dev_bits)
    else $error("device low run not whole bits");
  property p_rem_bits; $rose(rem_tx) |-> rem_lo_q % BIT_CLKS == 0; endproperty
  a_rem_bits: assert property (p_rem_bits)
    else $error("remote low run not whole bits");
  property p_rem_max; $rose(rem_tx) |-> rem_lo_q <= REM_MAX_LOW; endproperty
  a_rem_max: assert property (p_rem_max)
    else $error("remote frame without stop bit");
  property p_oe_hold;
    $fell(dev_tx_oe) |-> $past(dev_tx) && dev_hi_q >= BIT_CLKS;
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("pin released before last bit ended");
  property p_reset_idle;
    $fell(rst) |-> dev_tx && !dev_tx_oe && rem_tx;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("link not idle after reset");

  c_break: cover property ($rose(dev_tx) && dev_lo_q >= 160);
  c_release: cover property ($fell(dev_tx_oe));
  c_rem_frame: cover property ($rose(rem_tx) && rem_lo_q != 0);
endmodule : usbir_link_sva
